// ### sps_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none
module sps_baud_gen import sps_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] div,
	output logic tick
);
	// one pulse per oversample slot
	logic [15:0] cnt_reg;
	wire logic wrap = (cnt_reg >= div - 16'h0001);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
			tick <= wrap;
		end
	end
endmodule
`default_nettype wire

// ### sps_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sps_host_model #(
	parameter int BIT_CYC = 20832
) (
	input wire logic clk,
	input wire logic txd,
	input wire logic dtr,
	output logic rxd,
	output logic dsr
);
	initial begin
		rxd = 1'b1;
		dsr = 1'b1;
	end
	task set_dsr(input logic v);
		@(posedge clk);
		dsr <= v;
	endtask
	// start, eight bits lsb first, two stops
	task send8(input logic [7:0] c);
		logic [10:0] f;
		f = {2'b11, c, 1'b0};
		wait (dtr === 1'b1);
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
	endtask
	// samples each bit at its centre
	task recv(output logic [10:0] b);
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge clk);
		for (int i = 0; i < 11; i++) begin
			b[i] = txd;
			if (i < 10) repeat (BIT_CYC) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ### sps_pkg.sv
package sps_pkg;
	// clock and bit timing
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned BAUD_300 = 300;
	localparam int unsigned BAUD_600 = 600;
	localparam int unsigned BAUD_1200 = 1200;
	localparam int unsigned BAUD_2400 = 2400;
	localparam int unsigned BAUD_4800 = 4800;
	localparam int unsigned BAUD_9600 = 9600;
	localparam logic [15:0] DIV_300 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_300));
	localparam logic [15:0] DIV_600 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_600));
	localparam logic [15:0] DIV_1200 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_1200));
	localparam logic [15:0] DIV_2400 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_2400));
	localparam logic [15:0] DIV_4800 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_4800));
	localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_9600));
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] SUB_MID = 4'h7;

	typedef enum logic [2:0] {
		SPS_B300 = 3'h0, SPS_B600 = 3'h1, SPS_B1200 = 3'h2,
		SPS_B2400 = 3'h3, SPS_B4800 = 3'h4, SPS_B9600 = 3'h5
	} sps_baud_type;
	typedef enum logic [1:0] {
		SPS_FMT_8N = 2'h0, SPS_FMT_7E = 2'h1, SPS_FMT_7O = 2'h2
	} sps_fmt_type;
	typedef enum logic [1:0] {
		SPS_MODE_LOCAL = 2'h0, SPS_MODE_REMOTE = 2'h1, SPS_MODE_LOCKOUT = 2'h2
	} sps_mode_type;

	typedef struct packed {
		sps_mode_type mode;
		sps_fmt_type fmt;
		sps_baud_type baud;
	} sps_ctrl_type;
	localparam sps_ctrl_type CTRL_RESET = '{SPS_MODE_LOCAL, SPS_FMT_8N, SPS_B9600};
	localparam int unsigned CTRL_W = 7;

	typedef enum logic [5:0] {
		SPS_RX_IDLE = 6'h01, SPS_RX_START = 6'h02, SPS_RX_DATA = 6'h04,
		SPS_RX_PAR = 6'h08, SPS_RX_STOP = 6'h10
	} sps_rx_state_type;
	typedef enum logic [5:0] {
		SPS_TX_IDLE = 6'h01, SPS_TX_WAIT = 6'h02, SPS_TX_START = 6'h04,
		SPS_TX_DATA = 6'h08, SPS_TX_PAR = 6'h10, SPS_TX_STOP = 6'h20
	} sps_tx_state_type;

	// buffers
	localparam int unsigned RX_DEPTH = 128;
	localparam logic [7:0] RX_DEPTH_CNT = 8'h80;
	localparam logic [7:0] RX_FULL_LEVEL = 8'h64;
	localparam int unsigned TX_DEPTH = 64;
	localparam logic [6:0] TX_DEPTH_CNT = 7'h40;

	// characters
	localparam logic [7:0] CHAR_NEWLINE = 8'h0a;
	localparam logic [7:0] CHAR_ABORT = 8'h03;
	localparam logic [2:0] LAST_BIT_8 = 3'h7;
	localparam logic [2:0] LAST_BIT_7 = 3'h6;

	// register map (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_RXDATA = 8'h08;
	localparam logic [7:0] OFF_TXDATA = 8'h0c;
	localparam logic [7:0] OFF_CMD = 8'h10;
	localparam int unsigned ST_DTR = 16;
	localparam int unsigned ST_DSR = 17;
	localparam int unsigned ST_SUSP = 18;
	localparam int unsigned ST_QPEND = 19;
	localparam int unsigned ST_FERR = 20;
	localparam int unsigned ST_PERR = 21;
	localparam int unsigned ST_BREAK = 22;
	localparam int unsigned RXD_VALID = 8;
	localparam int unsigned TXD_LAST = 8;
	localparam int unsigned CMD_CLEAR = 0;
	localparam int unsigned CMD_QUERY = 1;
endpackage

// ### sps_serial_port.sv
`timescale 1ns/100ps
`default_nettype none
module sps_serial_port import sps_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	input wire logic dsr,
	output logic txd,
	output logic dtr,
	output logic key_local_en,
	output logic key_other_en,
	output logic abort_meas
);
	sps_ctrl_type ctrl_reg;
	logic rxd_s, dsr_s, tick;
	logic [15:0] baud_div;

	sps_sync #(.W(2), .RESET_VAL(2'h3)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({rxd, dsr}),
		.q({rxd_s, dsr_s})
	);

	// invalid codes fall back to the fastest rate
	assign baud_div = (ctrl_reg.baud == SPS_B300) ? DIV_300 :
		(ctrl_reg.baud == SPS_B600) ? DIV_600 :
		(ctrl_reg.baud == SPS_B1200) ? DIV_1200 :
		(ctrl_reg.baud == SPS_B2400) ? DIV_2400 :
		(ctrl_reg.baud == SPS_B4800) ? DIV_4800 : DIV_9600;

	sps_baud_gen u_baud (
		.clk(clk),
		.rst_n(rst_n),
		.div(baud_div),
		.tick(tick)
	);

	wire logic fmt8 = (ctrl_reg.fmt == SPS_FMT_8N);
	wire logic odd_par = (ctrl_reg.fmt == SPS_FMT_7O);
	wire logic [2:0] last_bit = fmt8 ? LAST_BIT_8 : LAST_BIT_7;

	// apb decode
	wire logic access = psel && penable;
	wire logic done = access && pready;
	wire logic wr_done = done && pwrite && !pslverr;
	wire logic hit_ctrl = (paddr == OFF_CTRL);
	wire logic hit_status = (paddr == OFF_STATUS);
	wire logic hit_rx = (paddr == OFF_RXDATA);
	wire logic hit_tx = (paddr == OFF_TXDATA);
	wire logic hit_cmd = (paddr == OFF_CMD);
	wire logic mapped = hit_ctrl || hit_status || hit_rx || hit_tx || hit_cmd;

	// receive path
	sps_rx_state_type rx_state;
	logic [3:0] rx_sub;
	logic [2:0] rx_bit;
	logic [7:0] rx_shift;
	logic rx_perr_bit;
	logic [7:0] rx_mem [RX_DEPTH];
	logic [6:0] rx_wr, rx_rd;
	logic [7:0] rx_count;
	logic query_armed, query_pending, ferr_reg, perr_reg, break_reg;

	wire logic rx_slot = tick && (rx_sub == SUB_LAST);
	wire logic [7:0] rx_char = fmt8 ? rx_shift : {1'b0, rx_shift[7:1]};
	wire logic rx_done = tick && (rx_sub == SUB_LAST) && (rx_state == SPS_RX_STOP);
	wire logic rx_abort = rx_done && (rx_char == CHAR_ABORT);
	wire logic rx_push = rx_done && !rx_abort && (rx_count != RX_DEPTH_CNT);
	wire logic rx_pop = done && !pwrite && hit_rx && prdata[RXD_VALID];

	// transmit path
	sps_tx_state_type tx_state;
	logic [3:0] tx_sub;
	logic [2:0] tx_bit;
	logic tx_stop2;
	logic [7:0] tx_shift;
	logic tx_par, tx_last;
	logic [8:0] tx_mem [TX_DEPTH];
	logic [5:0] tx_wr, tx_rd;
	logic [6:0] tx_count;

	wire logic tx_slot = tick && (tx_sub == SUB_LAST);
	wire logic tx_full = (tx_count == TX_DEPTH_CNT);
	wire logic tx_push = wr_done && hit_tx;
	wire logic tx_load = tx_slot && (tx_state == SPS_TX_WAIT) && dsr_s;
	wire logic resp_done = tx_slot && (tx_state == SPS_TX_STOP) && tx_stop2 && tx_last;
	wire logic suspended = (tx_state == SPS_TX_WAIT) && !dsr_s;
	wire logic [8:0] tx_word = tx_mem[tx_rd];

	wire logic clear_req = rx_abort || (wr_done && hit_cmd && pwdata[CMD_CLEAR]);

	wire logic dtr_next = !((rx_count >= RX_FULL_LEVEL) || query_pending || suspended);

	// register access
	wire logic [31:0] status_word = {9'h000, break_reg, perr_reg, ferr_reg, query_pending,
		suspended, dsr_s, dtr, 1'b0, tx_count, rx_count};
	wire logic [31:0] rd_mux = hit_ctrl ? {25'h0000000, ctrl_reg} :
		hit_status ? status_word :
		hit_rx ? {23'h000000, (rx_count != 8'h00), rx_mem[rx_rd]} : 32'h00000000;
	wire logic err_next = !mapped || (pwrite && hit_tx && tx_full);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access && !pready;
			pslverr <= access && !pready && err_next;
			prdata <= (access && !pready && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// configuration survives a clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_done && hit_ctrl) begin
			ctrl_reg <= sps_ctrl_type'(pwdata[CTRL_W-1:0]);
		end
	end

	// sticky status, set wins over write-one clear
	wire logic st_clr = wr_done && hit_status;
	wire logic ferr_set = rx_done && !rxd_s;
	wire logic perr_set = rx_done && rx_perr_bit;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ferr_reg <= 1'b0;
			perr_reg <= 1'b0;
			break_reg <= 1'b0;
		end else begin
			ferr_reg <= ferr_set || (ferr_reg && !(st_clr && pwdata[ST_FERR]));
			perr_reg <= perr_set || (perr_reg && !(st_clr && pwdata[ST_PERR]));
			break_reg <= rx_abort || (break_reg && !(st_clr && pwdata[ST_BREAK]));
		end
	end

	// receiver: centre sampling off the oversample tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_state <= SPS_RX_IDLE;
			rx_sub <= 4'h0;
			rx_bit <= 3'h0;
			rx_shift <= 8'h00;
			rx_perr_bit <= 1'b0;
		end else if (tick) begin
			rx_sub <= rx_sub + 4'h1;
			case (rx_state)
				SPS_RX_IDLE: begin
					rx_sub <= 4'h0;
					if (!rxd_s && dtr) begin
						rx_state <= SPS_RX_START;
					end
				end
				SPS_RX_START: begin
					if (rx_sub == SUB_MID) begin
						rx_sub <= 4'h0;
						rx_bit <= 3'h0;
						rx_perr_bit <= 1'b0;
						rx_state <= rxd_s ? SPS_RX_IDLE : SPS_RX_DATA;
					end
				end
				SPS_RX_DATA: begin
					if (rx_slot) begin
						rx_shift <= {rxd_s, rx_shift[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == last_bit) begin
							rx_state <= fmt8 ? SPS_RX_STOP : SPS_RX_PAR;
						end
					end
				end
				SPS_RX_PAR: begin
					if (rx_slot) begin
						rx_perr_bit <= (^rx_shift[7:1]) ^ rxd_s ^ odd_par;
						rx_state <= SPS_RX_STOP;
					end
				end
				SPS_RX_STOP: begin
					if (rx_slot) begin
						rx_state <= SPS_RX_IDLE;
					end
				end
				default: begin
					rx_state <= SPS_RX_IDLE;
				end
			endcase
		end
	end

	// receive buffer
	always_ff @(posedge clk) begin
		if (rx_push) begin
			rx_mem[rx_wr] <= rx_char;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n || clear_req) begin
			rx_wr <= 7'h00;
			rx_rd <= 7'h00;
			rx_count <= 8'h00;
		end else begin
			rx_wr <= rx_wr + {6'h00, rx_push};
			rx_rd <= rx_rd + {6'h00, rx_pop};
			rx_count <= rx_count + {7'h00, rx_push} - {7'h00, rx_pop};
		end
	end

	// query handshake: set wins over the response end
	wire logic nl_seen = rx_push && (rx_char == CHAR_NEWLINE);
	always_ff @(posedge clk) begin
		if (!rst_n || clear_req) begin
			query_armed <= 1'b0;
			query_pending <= 1'b0;
		end else begin
			query_armed <= (wr_done && hit_cmd && pwdata[CMD_QUERY]) || (query_armed && !nl_seen);
			query_pending <= (query_armed && nl_seen) || (query_pending && !resp_done);
		end
	end

	// transmit buffer
	always_ff @(posedge clk) begin
		if (tx_push) begin
			tx_mem[tx_wr] <= pwdata[TXD_LAST:0];
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n || clear_req) begin
			tx_wr <= 6'h00;
			tx_rd <= 6'h00;
			tx_count <= 7'h00;
		end else begin
			tx_wr <= tx_wr + {5'h00, tx_push};
			tx_rd <= tx_rd + {5'h00, tx_load};
			tx_count <= tx_count + {6'h00, tx_push} - {6'h00, tx_load};
		end
	end

	// transmitter: one bit per sixteen ticks
	always_ff @(posedge clk) begin
		if (!rst_n || clear_req) begin
			tx_state <= SPS_TX_IDLE;
			tx_sub <= 4'h0;
			tx_bit <= 3'h0;
			tx_stop2 <= 1'b0;
			tx_shift <= 8'h00;
			tx_par <= 1'b0;
			tx_last <= 1'b0;
			txd <= 1'b1;
		end else begin
			if (tick) begin
				tx_sub <= tx_sub + 4'h1;
			end
			case (tx_state)
				SPS_TX_IDLE: begin
					if (tx_count != 7'h00) begin
						tx_state <= SPS_TX_WAIT;
					end
				end
				SPS_TX_WAIT: begin
					if (tx_load) begin
						tx_shift <= tx_word[7:0];
						tx_last <= tx_word[TXD_LAST];
						tx_par <= (^tx_word[6:0]) ^ odd_par;
						txd <= 1'b0;
						tx_state <= SPS_TX_START;
					end
				end
				SPS_TX_START: begin
					if (tx_slot) begin
						txd <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_bit <= 3'h0;
						tx_state <= SPS_TX_DATA;
					end
				end
				SPS_TX_DATA: begin
					if (tx_slot) begin
						tx_bit <= tx_bit + 3'h1;
						txd <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						if (tx_bit == last_bit) begin
							txd <= fmt8 ? 1'b1 : tx_par;
							tx_stop2 <= 1'b0;
							tx_state <= fmt8 ? SPS_TX_STOP : SPS_TX_PAR;
						end
					end
				end
				SPS_TX_PAR: begin
					if (tx_slot) begin
						txd <= 1'b1;
						tx_stop2 <= 1'b0;
						tx_state <= SPS_TX_STOP;
					end
				end
				SPS_TX_STOP: begin
					if (tx_slot) begin
						tx_stop2 <= 1'b1;
						if (tx_stop2) begin
							tx_state <= SPS_TX_IDLE;
						end
					end
				end
				default: begin
					tx_state <= SPS_TX_IDLE;
				end
			endcase
		end
	end

	// handshake and panel outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dtr <= 1'b1;
			key_local_en <= 1'b1;
			key_other_en <= 1'b1;
			abort_meas <= 1'b0;
		end else begin
			dtr <= dtr_next;
			key_local_en <= (ctrl_reg.mode != SPS_MODE_LOCKOUT);
			key_other_en <= (ctrl_reg.mode == SPS_MODE_LOCAL);
			abort_meas <= clear_req;
		end
	end
endmodule
`default_nettype wire

// ### sps_serial_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module sps_serial_port_props import sps_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txd,
	input wire logic dtr,
	input wire logic key_local_en,
	input wire logic key_other_en,
	input wire logic abort_meas
);
	localparam int LOW_MIN = 20830;
	int run_cnt;
	logic txd_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// length of the current stretch on txd, at either level
	always_ff @(posedge clk) begin
		txd_q <= txd;
		run_cnt <= (!rst_n || txd != txd_q) ? 0 : run_cnt + 1;
	end
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence apb_wait;
		!pready ##1 pready;
	endsequence
	AST_APB_WAIT: assert property (apb_setup |=> apb_wait)
		else $error("ready not in second access cycle");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside ready");
	AST_KEY_ORDER: assert property (key_other_en |-> key_local_en)
		else $error("keys enabled while local key locked");
	AST_KEY_CAUSE: assert property ($changed({key_local_en, key_other_en})
		|-> $past(pready && pwrite && paddr == OFF_CTRL, 2))
		else $error("keys changed without control write");
	AST_ABORT_PULSE: assert property (abort_meas |=> !abort_meas)
		else $error("abort pulse too long");
	AST_ABORT_TXD: assert property (abort_meas |-> ##[0:2] txd)
		else $error("output not idle after abort");
	AST_CLEAR_DTR: assert property (abort_meas |-> ##[1:3] dtr)
		else $error("dtr low after clear");
	AST_CLEAR_CFG: assert property (abort_meas |-> $stable({key_local_en, key_other_en}))
		else $error("clear changed configuration");
	AST_BIT_LEN: assert property ($rose(txd) && !abort_meas && !$past(abort_meas)
		&& !$past(abort_meas, 2) |-> run_cnt >= LOW_MIN)
		else $error("low bit shorter than a bit time");
endmodule
bind sps_serial_port sps_serial_port_props u_props (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .txd(txd), .dtr(dtr), .key_local_en(key_local_en),
	.key_other_en(key_other_en), .abort_meas(abort_meas));
`default_nettype wire

// ### sps_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sps_sync import sps_pkg::*; #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ### test_serial_port_dtr_dsr_flow.sv
`timescale 1ns/100ps
`default_nettype none
module test_serial_port_dtr_dsr_flow import sps_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, rxd, dsr, txd, dtr, kl, ko, abm;
	logic [10:0] bits;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	sps_serial_port dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .dsr(dsr), .txd(txd), .dtr(dtr), .key_local_en(kl),
		.key_other_en(ko), .abort_meas(abm));
	sps_host_model host (.clk(clk), .txd(txd), .dtr(dtr), .rxd(rxd), .dsr(dsr));
	task complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 600000) begin
			num_errors++;
			complete_run();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task t_regs();
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h05);
		chk(32'({kl, ko}), 32'h3);
		apb(1'b0, 8'h14, 32'h0);
		chk(32'(err), 32'h1);
		$display("register test done");
	endtask
	task t_modes();
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, OFF_CTRL, 32'h05 | (32'(m) << 5));
			repeat (2) @(posedge clk);
			chk(32'({kl, ko}), m == 0 ? 32'h3 : (m == 1 ? 32'h2 : 32'h0));
		end
		$display("mode test done");
	endtask
	task t_susp();
		host.set_dsr(1'b0);
		apb(1'b1, OFF_TXDATA, 32'h41);
		repeat (2700) @(posedge clk);
		chk(32'({txd, dtr}), 32'h2);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rd[ST_SUSP]), 32'h1);
		apb(1'b1, OFF_CMD, 32'h1);
		@(negedge clk);
		chk(32'(abm), 32'h1);
		@(negedge clk);
		chk(32'(abm), 32'h0);
		repeat (3) @(posedge clk);
		chk(32'(dtr), 32'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h47fff, 32'h0);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h45);
		host.set_dsr(1'b1);
		$display("suspend test done");
	endtask
	task t_frame();
		apb(1'b1, OFF_CTRL, 32'h2d);
		apb(1'b1, OFF_TXDATA, 32'h35);
		host.recv(bits);
		chk(32'(bits), {21'h0, 2'b11, ^7'h35, 7'h35, 1'b0});
		repeat (20900) @(posedge clk);
		$display("frame test done");
	endtask
	task t_query();
		apb(1'b1, OFF_CTRL, 32'h25);
		apb(1'b1, OFF_CMD, 32'h2);
		host.send8(CHAR_NEWLINE);
		repeat (4) @(posedge clk);
		chk(32'(dtr), 32'h0);
		apb(1'b0, OFF_RXDATA, 32'h0);
		chk(rd, {23'h0, 1'b1, CHAR_NEWLINE});
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(32'(rd[ST_QPEND]), 32'h1);
		apb(1'b1, OFF_CMD, 32'h1);
		repeat (3) @(posedge clk);
		chk(32'(dtr), 32'h1);
		$display("query test done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_modes();
		t_susp();
		t_frame();
		t_query();
		complete_run();
	end
endmodule
`default_nettype wire
